// ===== csf_pkg.sv
// constants, types and register map of the core status flag logic
package csf_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int CYC_W  = 4;

  localparam logic [ADDR_W-1:0] CTRL_OFS   = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] RES_LO_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] RES_HI_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] DIR0_OFS   = 5'h10;
  localparam logic [ADDR_W-1:0] DIR1_OFS   = 5'h14;

  // processor status word bit positions
  localparam int PSW_C = 0;
  localparam int PSW_Z = 1;
  localparam int PSW_I = 2;
  localparam int PSW_D = 3;
  localparam int PSW_B = 4;
  localparam int PSW_T = 5;
  localparam int PSW_V = 6;
  localparam int PSW_N = 7;

  localparam logic [DATA_W-1:0] PSW_RESET = 8'h04;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'h00;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BUSY_BIT = 7;

  typedef enum logic [1:0] {
    SPEED_HIGH   = 2'h0,
    SPEED_MIDDLE = 2'h1,
    SPEED_LOW    = 2'h2
  } csf_speed_t;

  // middle speed: phi half period is four main oscillator cycles
  localparam logic [1:0] MID_HALF_LAST = 2'h3;

  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ   = 4'h6;
  localparam logic [DATA_W-1:0] DIV_ZERO_QUOT = 8'hFF;
  localparam logic [CYC_W-1:0]  MIN_CYCLES    = 4'h1;

  typedef enum logic [3:0] {
    NOP_OP                  = 4'h0,
    ADD_WITH_CARRY_OP       = 4'h1,
    SUBTRACT_WITH_BORROW_OP = 4'h2,
    MULTIPLY_OP             = 4'h3,
    DIVIDE_OP               = 4'h4,
    SET_CARRY_OP            = 4'h5,
    CLEAR_CARRY_OP          = 4'h6,
    SET_DECIMAL_OP          = 4'h7,
    CLEAR_DECIMAL_OP        = 4'h8,
    SET_INDEX_MODE_OP       = 4'h9,
    CLEAR_INDEX_MODE_OP     = 4'hA
  } csf_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } csf_state_t;

  typedef struct packed {
    csf_op_t           op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [CYC_W-1:0]  cycles;
  } csf_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] hi;
    logic [DATA_W-1:0] lo;
  } csf_res_t;

endpackage

// ===== csf_core.sv
// status flag, arithmetic and core clock logic of an 8-bit processor core
// Overview of operation
// - reset forces interrupt mask to 1; other status bits may be anything
// - only add and subtract give decimal results when decimal flag is 1
// - decimal add or subtract leaves negative, overflow, zero meaningless
// - decimal carry flag is 1 on carry and 0 on borrow
// - multiply and divide ignore index mode and decimal flags
// - multiply and divide leave the whole status word unchanged
// - port direction registers are write only; reads never return them
// - phi is 2 main, 8 main or 2 sub oscillator cycles by speed mode
// - an instruction takes its cycle count times one phi period; a cycle count of 0 takes one period
`timescale 1ns/10ps
module csf_core (
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  input  wire logic [csf_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [csf_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [csf_pkg::DATA_W-1:0]  rdata_o,
  input  wire logic                        sub_osc_input_i,
  input  wire logic                        op_valid_i,
  input  wire csf_pkg::csf_req_t           op_req_i,
  output logic                             op_ready_o,
  output logic                             op_done_o,
  output csf_pkg::csf_res_t                result_o,
  output logic      [csf_pkg::DATA_W-1:0]  processor_status_word_o,
  output logic                             phi_o,
  output logic      [csf_pkg::DATA_W-1:0]  dir0_o,
  output logic      [csf_pkg::DATA_W-1:0]  dir1_o
);

  csf_pkg::csf_state_t state_r;
  csf_pkg::csf_speed_t mode_r;
  csf_pkg::csf_req_t   req_r;
  csf_pkg::csf_res_t   res_r;
  csf_pkg::csf_res_t   res_nxt;
  logic [csf_pkg::DATA_W-1:0] psw_r;
  logic [csf_pkg::DATA_W-1:0] psw_pend_r;
  logic [csf_pkg::DATA_W-1:0] psw_nxt;
  logic [csf_pkg::DATA_W-1:0] dir0_r;
  logic [csf_pkg::DATA_W-1:0] dir1_r;
  logic [csf_pkg::DATA_W-1:0] rdata_r;
  logic [csf_pkg::CYC_W-1:0]  left_r;
  logic [1:0]                 div_cnt_r;
  logic                       phi_r;
  logic                       done_r;
  logic                       sub_s1_r;
  logic                       sub_s2_r;
  logic                       sub_s3_r;
  logic                       toggle;
  logic                       tick;
  logic                       accept;
  logic [8:0]                 dec_add;
  logic [8:0]                 dec_sub;
  logic [8:0]                 bin_sum;
  logic [7:0]                 b_eff;

  function automatic logic [8:0] bcd_add(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       c);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       cl;
    logic       ch;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    cl = lo > {1'b0, csf_pkg::BCD_LIMIT};
    if (cl) begin
      lo = lo + {1'b0, csf_pkg::BCD_ADJ};
    end
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, cl};
    ch = hi > {1'b0, csf_pkg::BCD_LIMIT};
    if (ch) begin
      hi = hi + {1'b0, csf_pkg::BCD_ADJ};
    end
    return {ch, hi[3:0], lo[3:0]};
  endfunction

  function automatic logic [8:0] bcd_sub(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       c);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       bl;
    logic       bh;
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
    bl = lo[4];
    if (bl) begin
      lo = lo - {1'b0, csf_pkg::BCD_ADJ};
    end
    hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, bl};
    bh = hi[4];
    if (bh) begin
      hi = hi - {1'b0, csf_pkg::BCD_ADJ};
    end
    return {~bh, hi[3:0], lo[3:0]};
  endfunction

  // sub oscillator pin crosses into the main clock domain
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
    end else begin
      sub_s1_r <= sub_osc_input_i;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
    end
  end

  always_comb begin
    unique case (mode_r)
      csf_pkg::SPEED_HIGH:   toggle = 1'b1;
      csf_pkg::SPEED_MIDDLE: toggle = div_cnt_r == csf_pkg::MID_HALF_LAST;
      csf_pkg::SPEED_LOW:    toggle = sub_s2_r & ~sub_s3_r;
      default:               toggle = 1'b1;
    endcase
  end

  // one tick per phi period, on its rising edge
  assign tick = toggle & ~phi_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_r <= 2'h0;
      phi_r     <= 1'b0;
    end else begin
      div_cnt_r <= toggle ? 2'h0 : div_cnt_r + 2'h1;
      if (toggle) begin
        phi_r <= ~phi_r;
      end
    end
  end

  always_comb begin
    b_eff   = (op_req_i.op == csf_pkg::SUBTRACT_WITH_BORROW_OP)
              ? ~op_req_i.b : op_req_i.b;
    bin_sum = {1'b0, op_req_i.a} + {1'b0, b_eff}
              + {8'h00, psw_r[csf_pkg::PSW_C]};
    dec_add = bcd_add(op_req_i.a, op_req_i.b, psw_r[csf_pkg::PSW_C]);
    dec_sub = bcd_sub(op_req_i.a, op_req_i.b, psw_r[csf_pkg::PSW_C]);
    psw_nxt = psw_r;
    res_nxt = '{hi: 8'h00, lo: 8'h00};
    unique case (op_req_i.op)
      csf_pkg::ADD_WITH_CARRY_OP, csf_pkg::SUBTRACT_WITH_BORROW_OP: begin
        if (psw_r[csf_pkg::PSW_D]) begin
          // N, V and Z carry no meaning here and are left alone
          res_nxt.lo = (op_req_i.op == csf_pkg::ADD_WITH_CARRY_OP)
                       ? dec_add[7:0] : dec_sub[7:0];
          psw_nxt[csf_pkg::PSW_C] = (op_req_i.op == csf_pkg::ADD_WITH_CARRY_OP)
                       ? dec_add[8] : dec_sub[8];
        end else begin
          res_nxt.lo = bin_sum[7:0];
          psw_nxt[csf_pkg::PSW_C] = bin_sum[8];
          psw_nxt[csf_pkg::PSW_Z] = bin_sum[7:0] == 8'h00;
          psw_nxt[csf_pkg::PSW_N] = bin_sum[7];
          psw_nxt[csf_pkg::PSW_V] = ~(op_req_i.a[7] ^ b_eff[7])
                                    & (op_req_i.a[7] ^ bin_sum[7]);
        end
      end
      csf_pkg::MULTIPLY_OP: begin
        // status word untouched; T and D never looked at
        {res_nxt.hi, res_nxt.lo} = 16'(op_req_i.a)
                                   * 16'(op_req_i.b);
      end
      csf_pkg::DIVIDE_OP: begin
        if (op_req_i.b == 8'h00) begin
          res_nxt.lo = csf_pkg::DIV_ZERO_QUOT;
          res_nxt.hi = op_req_i.a;
        end else begin
          res_nxt.lo = op_req_i.a / op_req_i.b;
          res_nxt.hi = op_req_i.a % op_req_i.b;
        end
      end
      csf_pkg::SET_CARRY_OP:        psw_nxt[csf_pkg::PSW_C] = 1'b1;
      csf_pkg::CLEAR_CARRY_OP:      psw_nxt[csf_pkg::PSW_C] = 1'b0;
      csf_pkg::SET_DECIMAL_OP:
        psw_nxt[csf_pkg::PSW_D] = 1'b1;
      csf_pkg::CLEAR_DECIMAL_OP:    psw_nxt[csf_pkg::PSW_D] = 1'b0;
      csf_pkg::SET_INDEX_MODE_OP:   psw_nxt[csf_pkg::PSW_T] = 1'b1;
      csf_pkg::CLEAR_INDEX_MODE_OP: psw_nxt[csf_pkg::PSW_T] = 1'b0;
      default: ;
    endcase
  end

  assign accept = op_valid_i & (state_r == csf_pkg::ST_IDLE);

  // results are worked out and stored on acceptance; the status word is committed after the last period
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= csf_pkg::ST_IDLE;
      req_r      <= '0;
      left_r     <= '0;
      psw_pend_r <= csf_pkg::PSW_RESET;
      res_r      <= '0;
      psw_r      <= csf_pkg::PSW_RESET;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        csf_pkg::ST_IDLE: begin
          if (op_valid_i) begin
            state_r    <= csf_pkg::ST_BUSY;
            req_r      <= op_req_i;
            psw_pend_r <= psw_nxt;
            res_r      <= res_nxt;
            left_r     <= (op_req_i.cycles == '0) ? csf_pkg::MIN_CYCLES
                                                 : op_req_i.cycles;
          end
        end
        csf_pkg::ST_BUSY: begin
          if (tick) begin
            left_r <= left_r - csf_pkg::MIN_CYCLES;
            if (left_r == csf_pkg::MIN_CYCLES) begin
              state_r <= csf_pkg::ST_IDLE;
              psw_r   <= psw_pend_r;
              done_r  <= 1'b1;
            end
          end
        end
        default: state_r <= csf_pkg::ST_IDLE;
      endcase
    end
  end

  // register write side; direction registers have no read path at all
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= csf_pkg::SPEED_HIGH;
      dir0_r <= csf_pkg::DIR_RESET;
      dir1_r <= csf_pkg::DIR_RESET;
    end else if (wr_i) begin
      unique case (addr_i)
        csf_pkg::CTRL_OFS:
          mode_r <= csf_pkg::csf_speed_t'(wdata_i[csf_pkg::CTRL_MODE_LSB +: 2]);
        csf_pkg::DIR0_OFS: dir0_r <= wdata_i;
        csf_pkg::DIR1_OFS: dir1_r <= wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (rd_i) begin
        unique case (addr_i)
          csf_pkg::CTRL_OFS: begin
            rdata_r[csf_pkg::CTRL_MODE_LSB +: 2] <= mode_r;
            rdata_r[csf_pkg::CTRL_BUSY_BIT] <= state_r == csf_pkg::ST_BUSY;
          end
          csf_pkg::STATUS_OFS: rdata_r <= psw_r;
          csf_pkg::RES_LO_OFS: rdata_r <= res_r.lo;
          csf_pkg::RES_HI_OFS: rdata_r <= res_r.hi;
          default:             rdata_r <= '0;
        endcase
      end
    end
  end

  assign rdata_o                 = rdata_r;
  assign op_ready_o              = state_r[0];
  assign op_done_o               = done_r;
  assign result_o                = res_r;
  assign processor_status_word_o = psw_r;
  assign phi_o                   = phi_r;
  assign dir0_o                  = dir0_r;
  assign dir1_o                  = dir1_r;

  // helper logic for the checks below
  logic [7:0] elapsed_r;
  logic       hi_steady_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      elapsed_r   <= '0;
      hi_steady_r <= 1'b0;
    end else begin
      elapsed_r   <= accept ? 8'h00 : elapsed_r + 8'h01;
      hi_steady_r <= accept ? (mode_r == csf_pkg::SPEED_HIGH)
                            : hi_steady_r & (mode_r == csf_pkg::SPEED_HIGH);
    end
  end

  function automatic int bcd_val(input logic [7:0] v);
    return int'(v[7:4]) * 10 + int'(v[3:0]);
  endfunction

  function automatic logic bcd_ok(input logic [7:0] v);
    return v[7:4] <= csf_pkg::BCD_LIMIT && v[3:0] <= csf_pkg::BCD_LIMIT;
  endfunction

  property p_reset_imask;
    @(posedge clock_i) disable iff (!nrst_i)
      !$past(nrst_i) |-> psw_r[csf_pkg::PSW_I];
  endproperty
  a_reset_imask: assert property (p_reset_imask)
    else $error("interrupt mask not set after reset");

  property p_sed_sets_d;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && req_r.op == csf_pkg::SET_DECIMAL_OP |-> psw_r[csf_pkg::PSW_D];
  endproperty
  a_sed_sets_d: assert property (p_sed_sets_d)
    else $error("decimal flag not set");

  property p_dec_add_value;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && req_r.op == csf_pkg::ADD_WITH_CARRY_OP && psw_r[csf_pkg::PSW_D]
      && bcd_ok(req_r.a) && bcd_ok(req_r.b)
      |-> bcd_val(res_r.lo) + 100 * int'(psw_r[csf_pkg::PSW_C]) ==
          bcd_val(req_r.a) + bcd_val(req_r.b)
          + int'($past(psw_r[csf_pkg::PSW_C]));
  endproperty
  a_dec_add_value: assert property (p_dec_add_value)
    else $error("decimal add result or carry wrong");

  property p_dec_nvz_kept;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && psw_r[csf_pkg::PSW_D] &&
      (req_r.op inside {csf_pkg::ADD_WITH_CARRY_OP,
                        csf_pkg::SUBTRACT_WITH_BORROW_OP})
      |-> psw_r[csf_pkg::PSW_N] == $past(psw_r[csf_pkg::PSW_N])
          && psw_r[csf_pkg::PSW_V] == $past(psw_r[csf_pkg::PSW_V])
          && psw_r[csf_pkg::PSW_Z] == $past(psw_r[csf_pkg::PSW_Z]);
  endproperty
  a_dec_nvz_kept: assert property (p_dec_nvz_kept)
    else $error("decimal op disturbed N V Z");

  property p_muldiv_psw;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && (req_r.op inside {csf_pkg::MULTIPLY_OP, csf_pkg::DIVIDE_OP})
      |-> psw_r == $past(psw_r);
  endproperty
  a_muldiv_psw: assert property (p_muldiv_psw)
    else $error("multiply or divide changed status word");

  property p_mul_value;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && req_r.op == csf_pkg::MULTIPLY_OP
      |-> {res_r.hi, res_r.lo} == 16'(req_r.a) * 16'(req_r.b);
  endproperty
  a_mul_value: assert property (p_mul_value)
    else $error("multiply result wrong");

  property p_dir_unreadable;
    @(posedge clock_i) disable iff (!nrst_i)
      rd_i && (addr_i == csf_pkg::DIR0_OFS || addr_i == csf_pkg::DIR1_OFS)
      |=> rdata_o == 8'h00;
  endproperty
  a_dir_unreadable: assert property (p_dir_unreadable)
    else $error("direction register read back");

  property p_mid_period;
    @(posedge clock_i) disable iff (!nrst_i)
      $rose(phi_r) && mode_r == csf_pkg::SPEED_MIDDLE
      |-> ##4 ($fell(phi_r) || mode_r != csf_pkg::SPEED_MIDDLE);
  endproperty
  a_mid_period: assert property (p_mid_period)
    else $error("middle speed phi half period not four cycles");

  property p_exec_time;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && hi_steady_r && req_r.cycles != '0
      |-> elapsed_r >= 8'(2 * req_r.cycles - 1)
          && elapsed_r <= 8'(2 * req_r.cycles + 1);
  endproperty
  a_exec_time: assert property (p_exec_time)
    else $error("execution time not cycles times phi period");

  property p_bin_flags;
    @(posedge clock_i) disable iff (!nrst_i)
      done_r && req_r.op == csf_pkg::ADD_WITH_CARRY_OP
      && !psw_r[csf_pkg::PSW_D]
      |-> psw_r[csf_pkg::PSW_Z] == (res_r.lo == 8'h00)
          && psw_r[csf_pkg::PSW_N] == res_r.lo[7]
          && {psw_r[csf_pkg::PSW_C], res_r.lo} == 9'(req_r.a) + 9'(req_r.b)
             + 9'($past(psw_r[csf_pkg::PSW_C]));
  endproperty
  a_bin_flags: assert property (p_bin_flags)
    else $error("binary add flags wrong");

endmodule

// ===== csf_core_bench.sv
// self-checking testbench of the core status flag logic
`timescale 1ns/10ps
module csf_core_bench;
  logic                       clock_i;
  logic                       nrst_i;
  logic [csf_pkg::ADDR_W-1:0] addr_i;
  logic [csf_pkg::DATA_W-1:0] wdata_i;
  logic                       wr_i;
  logic                       rd_i;
  logic [csf_pkg::DATA_W-1:0] rdata_o;
  logic                       sub_osc_input_i;
  logic                       op_valid_i;
  csf_pkg::csf_req_t          op_req_i;
  logic                       op_ready_o;
  logic                       op_done_o;
  csf_pkg::csf_res_t          result_o;
  logic [csf_pkg::DATA_W-1:0] processor_status_word_o;
  logic                       phi_o;
  logic [csf_pkg::DATA_W-1:0] dir0_o;
  logic [csf_pkg::DATA_W-1:0] dir1_o;
  int                         n_mismatch;
  int                         comparisons;
  int                         lat;
  logic [7:0]                 d;
  logic [7:0]                 psw_hold;

  csf_core dut (
    .clock_i                 (clock_i),
    .nrst_i                  (nrst_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .sub_osc_input_i         (sub_osc_input_i),
    .op_valid_i              (op_valid_i),
    .op_req_i                (op_req_i),
    .op_ready_o              (op_ready_o),
    .op_done_o               (op_done_o),
    .result_o                (result_o),
    .processor_status_word_o (processor_status_word_o),
    .phi_o                   (phi_o),
    .dir0_o                  (dir0_o),
    .dir1_o                  (dir1_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // sub oscillator free-running at 170 ns, unrelated to the main clock
  initial begin
    sub_osc_input_i = 1'b0;
    #3;
    forever #85 sub_osc_input_i = ~sub_osc_input_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // returns clocks from acceptance to the done pulse
  task automatic run_op(input csf_pkg::csf_op_t op, input logic [7:0] a,
                        input logic [7:0] b, input logic [3:0] cyc,
                        output int n);
    int k;
    @(posedge clock_i);
    op_valid_i <= 1'b1;
    op_req_i   <= '{op: op, a: a, b: b, cycles: cyc};
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (op_ready_o !== 1'b1 && k < 50);
    op_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (op_done_o !== 1'b1 && n < 300);
    #1;
    check(16'(k < 50 && n < 300), 16'h0001);
  endtask

  task automatic phi_period(input real exp_ns, input real tol);
    realtime t0;
    realtime dt;
    @(posedge phi_o);
    @(posedge phi_o);
    t0 = $realtime;
    @(posedge phi_o);
    dt = $realtime - t0;
    check(16'((dt >= exp_ns - tol) && (dt <= exp_ns + tol)),
          16'h0001);
  endtask

  task automatic t_reset();
    check(16'(processor_status_word_o), 16'h0004);
    check(16'(op_ready_o), 16'h0001);
    reg_rd(csf_pkg::STATUS_OFS, d);
    check(16'(d), 16'h0004);
  endtask

  task automatic t_binary();
    run_op(csf_pkg::CLEAR_CARRY_OP, 8'h00, 8'h00, 4'h1, lat);
    run_op(csf_pkg::ADD_WITH_CARRY_OP, 8'h7F, 8'h01, 4'h2, lat);
    check(16'(result_o.lo), 16'h0080);
    check(16'(processor_status_word_o), 16'h00C4);
    run_op(csf_pkg::SET_CARRY_OP, 8'h00, 8'h00, 4'h1, lat);
    run_op(csf_pkg::SUBTRACT_WITH_BORROW_OP, 8'h00, 8'h01, 4'h2, lat);
    check(16'(result_o.lo), 16'h00FF);
    check(16'(processor_status_word_o), 16'h0084);
    run_op(csf_pkg::ADD_WITH_CARRY_OP, 8'hFF, 8'h01, 4'h2, lat);
    check(16'(result_o.lo), 16'h0000);
    check(16'(processor_status_word_o), 16'h0007);
  endtask

  // after the decimal ops only carry, decimal and mask are judged: the rest is meaningless here
  task automatic t_decimal();
    run_op(csf_pkg::SET_DECIMAL_OP, 8'h00, 8'h00, 4'h1, lat);
    check(16'(processor_status_word_o), 16'h000F);
    run_op(csf_pkg::CLEAR_CARRY_OP, 8'h00, 8'h00, 4'h1, lat);
    run_op(csf_pkg::ADD_WITH_CARRY_OP, 8'h58, 8'h46, 4'h2, lat);
    check(16'(result_o.lo), 16'h0004);
    check(16'(processor_status_word_o & 8'h0D), 16'h000D);
    // an ordinary instruction separates the decimal op from flag ops
    run_op(csf_pkg::NOP_OP, 8'h00, 8'h00, 4'h1, lat);
    run_op(csf_pkg::SET_CARRY_OP, 8'h00, 8'h00, 4'h1, lat);
    run_op(csf_pkg::SUBTRACT_WITH_BORROW_OP, 8'h12, 8'h34, 4'h2, lat);
    check(16'(result_o.lo), 16'h0078);
    check(16'(processor_status_word_o & 8'h0D), 16'h000C);
    run_op(csf_pkg::NOP_OP, 8'h00, 8'h00, 4'h1, lat);
  endtask

  task automatic t_muldiv();
    run_op(csf_pkg::SET_INDEX_MODE_OP, 8'h00, 8'h00, 4'h1, lat);
    // index mode and decimal both set, carry clear, mask and zero set
    psw_hold = 8'h2E;
    check(16'(processor_status_word_o), 16'(psw_hold));
    run_op(csf_pkg::MULTIPLY_OP, 8'h12, 8'h34, 4'h3, lat);
    check(16'(result_o), 16'h03A8);
    check(16'(processor_status_word_o), 16'(psw_hold));
    run_op(csf_pkg::DIVIDE_OP, 8'h64, 8'h07, 4'h3, lat);
    check(16'(result_o), 16'h020E);
    check(16'(processor_status_word_o), 16'(psw_hold));
    run_op(csf_pkg::DIVIDE_OP, 8'h55, 8'h00, 4'h3, lat);
    check(16'(result_o), 16'h55FF);
    check(16'(processor_status_word_o), 16'(psw_hold));
    run_op(csf_pkg::CLEAR_DECIMAL_OP, 8'h00, 8'h00, 4'h1, lat);
    run_op(csf_pkg::CLEAR_INDEX_MODE_OP, 8'h00, 8'h00, 4'h1, lat);
    psw_hold = 8'h06;
    check(16'(processor_status_word_o), 16'(psw_hold));
    run_op(csf_pkg::MULTIPLY_OP, 8'h12, 8'h34, 4'h3, lat);
    check(16'(result_o), 16'h03A8);
    check(16'(processor_status_word_o), 16'(psw_hold));
    reg_rd(csf_pkg::RES_LO_OFS, d);
    check(16'(d), 16'h00A8);
    reg_rd(csf_pkg::RES_HI_OFS, d);
    check(16'(d), 16'h0003);
    reg_wr(csf_pkg::STATUS_OFS, 8'hFF);
    reg_rd(csf_pkg::STATUS_OFS, d);
    check(16'(d), 16'(psw_hold));
  endtask

  task automatic t_dir();
    reg_wr(csf_pkg::DIR0_OFS, 8'hA5);
    reg_wr(csf_pkg::DIR1_OFS, 8'h3C);
    check(16'(dir0_o), 16'h00A5);
    check(16'(dir1_o), 16'h003C);
    reg_rd(csf_pkg::DIR0_OFS, d);
    check(16'(d), 16'h0000);
    reg_rd(csf_pkg::DIR1_OFS, d);
    check(16'(d), 16'h0000);
    reg_rd(5'h1C, d);
    check(16'(d), 16'h0000);
  endtask

  // instruction time follows the phi period in each speed
  task automatic t_speed();
    phi_period(40.0, 1.0);
    run_op(csf_pkg::NOP_OP, 8'h00, 8'h00, 4'h3, lat);
    check(16'(lat >= 5 && lat <= 7), 16'h0001);
    reg_wr(csf_pkg::CTRL_OFS, 8'h01);
    reg_rd(csf_pkg::CTRL_OFS, d);
    check(16'(d), 16'h0001);
    phi_period(160.0, 1.0);
    run_op(csf_pkg::NOP_OP, 8'h00, 8'h00, 4'h2, lat);
    check(16'(lat >= 12 && lat <= 20), 16'h0001);
    reg_wr(csf_pkg::CTRL_OFS, 8'h02);
    phi_period(340.0, 21.0);
    // one period of 340 ns is about seventeen main clocks
    run_op(csf_pkg::NOP_OP, 8'h00, 8'h00, 4'h1, lat);
    check(16'(lat >= 2 && lat <= 19), 16'h0001);
    // the spare mode code falls back to high speed
    reg_wr(csf_pkg::CTRL_OFS, 8'h03);
    phi_period(40.0, 1.0);
    reg_wr(csf_pkg::CTRL_OFS, 8'h00);
    phi_period(40.0, 1.0);
  endtask

  initial begin
    n_mismatch  = 0;
    comparisons = 0;
    nrst_i      = 1'b0;
    addr_i      = '0;
    wdata_i     = '0;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    op_valid_i  = 1'b0;
    op_req_i    = '{op: csf_pkg::NOP_OP, a: 8'h00, b: 8'h00, cycles: 4'h1};
    // held for the minimum external reset width of the main oscillator
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_binary();
    t_decimal();
    t_muldiv();
    t_dir();
    t_speed();
    results();
  end

  // the whole run needs a few hundred clocks
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule
